// ### rtl/watchdog_and_reset_control.sv
// file: watchdog, low-voltage qualification and reset-source flags
// assumes: AHB-Lite slave (one word per register), slow sub clock and
// low-voltage indication are asynchronous pins, CPU events on ref_clk
//
// Summary of operation
// - key 10101 or 01010 enables; else reset
// - bad key resets after 2-3 sub clocks, flag set
// - select picks 2^8..2^18 sub clock timeout
// - overflow in run: full reset, expired flag
// - overflow asleep: expired flag, clear pc/sp only
// - bad key, clear, halt clear the count
// - key reset flag bit0, software clears only
// - flag register bits 6-3 read zero
// - low-voltage flag bit2 set, software clears
// - short low-voltage pulses are ignored
// - undefined threshold code resets, reloads 0x55
// - bad code resets after 2-3 sub clocks
// - code flag bit1 set on undefined code
// - low-voltage reset keeps threshold register
// - low-voltage reset disabled in power down
// - power-on zeroes pc, ports to inputs
// - watchdog run reset equals low-voltage reset
// - wake start-up delay by oscillator kind
// - run watchdog reset holds power-on delay
// - sub clock from low rc or crystal
// - power-down flag set by halt, cleared
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module watchdog_and_reset_control #(
	parameter int POWER_ON_CYCLES_P = wdt_rst_pkg::POWER_ON_CYCLES,
	parameter int OSC_KIND          = 0 // 0 high rc, 1 crystal, 2 low rc
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// analog and oscillator pins
	input  wire logic        low_rc_clk,
	input  wire logic        crystal_clk,
	input  wire logic        sub_clock_sel,
	input  wire logic        low_voltage_in,
	// cpu events, on ref_clk
	input  wire logic        clear_watchdog_instruction,
	input  wire logic        halt_instruction,
	// reset actions
	output logic             device_reset,
	output logic             pc_sp_clear,
	output logic             wake_pulse,
	output logic             watchdog_expired_flag,
	output logic             power_down_flag,
	output logic             low_voltage_enable
);
	// ==========================================
	// pin synchronisers and sub clock edge detect
	logic [1:0] lrc_s, xtl_s, lv_s, sel_s;
	logic       sub_d;
	// the source select is a pin too, so it is synchronised like the clocks
	wire sub_now  = sel_s[1] ? xtl_s[1] : lrc_s[1];
	wire sub_tick = sub_now & ~sub_d;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrc_s <= 2'h0;
			xtl_s <= 2'h0;
			lv_s  <= 2'h0;
			sel_s <= 2'h0;
			sub_d <= 1'b0;
		end else begin
			lrc_s <= {lrc_s[0], low_rc_clk};
			xtl_s <= {xtl_s[0], crystal_clk};
			lv_s  <= {lv_s[0], low_voltage_in};
			sel_s <= {sel_s[0], sub_clock_sel};
			sub_d <= sub_now;
		end
	end

	// ==========================================
	// registers and bus decode
	logic [7:0] watchdog_control, low_voltage_select;
	logic [2:0] reset_flags;
	logic       idle_sysclk_keep;
	logic       asleep;
	logic       ph_wr;
	logic [7:0] ph_addr;
	wire        take    = hsel & hready & htrans[1];
	wire        wr_wdc  = ph_wr & (ph_addr == wdt_rst_pkg::ADDR_WATCHDOG_CONTROL);
	wire        wr_flag = ph_wr & (ph_addr == wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL);
	wire        wr_lvs  = ph_wr & (ph_addr == wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT);
	wire [4:0]  key     = watchdog_control[wdt_rst_pkg::KEY_MSB:wdt_rst_pkg::KEY_LSB];
	wire        key_ok  = (key == wdt_rst_pkg::KEY_A) | (key == wdt_rst_pkg::KEY_B);
	wire        code_ok = (low_voltage_select == wdt_rst_pkg::CODE_0) |
	                      (low_voltage_select == wdt_rst_pkg::CODE_1) |
	                      (low_voltage_select == wdt_rst_pkg::CODE_2) |
	                      (low_voltage_select == wdt_rst_pkg::CODE_3);
	wire [7:0]  flag_rd = {idle_sysclk_keep, 4'h0, reset_flags};
	wire [7:0]  stat_rd = {4'h0, 2'h0, power_down_flag, watchdog_expired_flag};
	// read data registered one edge early so hrdata comes from a flop
	wire [7:0] next_rdata = (take & ~hwrite) ?
	                        ((haddr[7:0] == wdt_rst_pkg::ADDR_WATCHDOG_CONTROL)   ? watchdog_control :
	                         (haddr[7:0] == wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL) ? flag_rd :
	                         (haddr[7:0] == wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT) ? low_voltage_select :
	                         (haddr[7:0] == wdt_rst_pkg::ADDR_STATUS)             ? stat_rd : 8'h00) : 8'h00;

	// address phase capture; zero wait states, response always okay
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_wr     <= 1'b0;
			ph_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ph_wr   <= take & hwrite;
			ph_addr <= take ? haddr[7:0] : ph_addr;
			hrdata  <= {24'h00_0000, next_rdata};
		end
	end

	// ==========================================
	// corruption delay: 2 sub clock edges after a bad key or code
	logic [1:0] key_cnt, code_cnt;
	wire key_fire  = ~key_ok & sub_tick & (key_cnt == 2'(wdt_rst_pkg::CORRUPT_DELAY_SUB - 1));
	wire code_fire = ~code_ok & sub_tick & (code_cnt == 2'(wdt_rst_pkg::CORRUPT_DELAY_SUB - 1));
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_cnt  <= 2'h0;
			code_cnt <= 2'h0;
		end else begin
			key_cnt  <= key_ok ? 2'h0 : (sub_tick ? key_cnt + 2'h1 : key_cnt);
			code_cnt <= code_ok ? 2'h0 : (sub_tick ? code_cnt + 2'h1 : code_cnt);
		end
	end

	// ==========================================
	// low-voltage qualification in system cycles
	logic [7:0] lv_cnt;
	wire lv_fire = low_voltage_enable & lv_s[1] & (lv_cnt == 8'(wdt_rst_pkg::LV_MIN_CYCLES));
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			lv_cnt <= 8'h00;
		else if (!(lv_s[1] & low_voltage_enable))
			lv_cnt <= 8'h00;  // glitch shorter than the minimum is forgotten
		else if (lv_cnt != 8'(wdt_rst_pkg::LV_MIN_CYCLES))
			lv_cnt <= lv_cnt + 8'h01;
	end

	// ==========================================
	// watchdog counter on sub clock ticks
	logic [18:0] watchdog_counter;
	logic [18:0] limit;
	always_comb begin
		case (watchdog_control[wdt_rst_pkg::SEL_MSB:0])
			3'h0:    limit = 19'h00100;
			3'h1:    limit = 19'h00400;
			3'h2:    limit = 19'h01000;
			3'h3:    limit = 19'h04000;
			3'h4:    limit = 19'h08000;
			3'h5:    limit = 19'h10000;
			3'h6:    limit = 19'h20000;
			default: limit = 19'h40000;
		endcase
	end
	wire wd_clear = ~key_ok | clear_watchdog_instruction | halt_instruction;
	wire overflow = sub_tick & (watchdog_counter == limit - 19'h00001);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			watchdog_counter <= 19'h00000;
		else if (wd_clear | overflow | device_reset)
			watchdog_counter <= 19'h00000;
		else if (sub_tick)
			watchdog_counter <= watchdog_counter + 19'h00001;
	end

	// ==========================================
	// reset sequencer
	wdt_rst_pkg::seq_state_t state;
	logic [23:0] hold_cnt;
	logic [7:0]  startup;
	always_comb begin
		case (OSC_KIND)
			1:       startup = 8'(wdt_rst_pkg::STARTUP_CRYSTAL);
			2:       startup = 8'(wdt_rst_pkg::STARTUP_LOW_RC);
			default: startup = 8'(wdt_rst_pkg::STARTUP_HIGH_RC);
		endcase
	end
	wire run_reset = (overflow & ~asleep) | key_fire | code_fire | lv_fire;
	wire hold_done = hold_cnt == 24'(POWER_ON_CYCLES_P - 1);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= wdt_rst_pkg::ST_HOLD;  // power-on holds too
			hold_cnt     <= 24'h000000;
			device_reset <= 1'b1;
			pc_sp_clear  <= 1'b0;
			wake_pulse   <= 1'b0;
		end else begin
			pc_sp_clear <= 1'b0;
			wake_pulse  <= 1'b0;
			case (state)
				wdt_rst_pkg::ST_RUN: begin
					hold_cnt <= 24'h000000;
					if (run_reset) begin
						state        <= wdt_rst_pkg::ST_HOLD;
						device_reset <= 1'b1;
					end else if (overflow & asleep) begin
						state <= wdt_rst_pkg::ST_WAKE;
					end
				end
				wdt_rst_pkg::ST_HOLD: begin
					hold_cnt <= hold_cnt + 24'h000001;
					if (hold_done) begin
						state        <= wdt_rst_pkg::ST_RUN;
						device_reset <= 1'b0;
					end
				end
				wdt_rst_pkg::ST_WAKE: begin
					hold_cnt <= hold_cnt + 24'h000001;
					if (hold_cnt == 24'(startup - 8'h01)) begin
						state       <= wdt_rst_pkg::ST_RUN;
						pc_sp_clear <= 1'b1;
						wake_pulse  <= 1'b1;
					end
				end
				default: begin
					state        <= wdt_rst_pkg::ST_HOLD;
					device_reset <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// register file and flags; hardware set wins over software clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_control      <= wdt_rst_pkg::RST_WATCHDOG_CONTROL;
			low_voltage_select    <= wdt_rst_pkg::RST_LOW_VOLTAGE_SELECT;
			reset_flags           <= 3'h0;
			idle_sysclk_keep      <= 1'b0;
			watchdog_expired_flag <= 1'b0;
			power_down_flag       <= 1'b0;
			asleep                <= 1'b0;
			low_voltage_enable    <= 1'b1;
		end else begin
			if (key_fire | (overflow & ~asleep) | code_fire | lv_fire)
				watchdog_control <= wdt_rst_pkg::RST_WATCHDOG_CONTROL;
			else if (wr_wdc)
				watchdog_control <= hwdata[7:0];
			if (code_fire)
				low_voltage_select <= wdt_rst_pkg::RST_LOW_VOLTAGE_SELECT;
			else if (wr_lvs)
				low_voltage_select <= hwdata[7:0];  // lv_fire leaves it alone
			if (wr_flag)
				idle_sysclk_keep <= hwdata[wdt_rst_pkg::FLAG_IDLE_KEEP];
			reset_flags[wdt_rst_pkg::FLAG_KEY] <= key_fire |
				(reset_flags[wdt_rst_pkg::FLAG_KEY] & ~(wr_flag & ~hwdata[wdt_rst_pkg::FLAG_KEY]));
			reset_flags[wdt_rst_pkg::FLAG_CODE] <= ~code_ok |
				(reset_flags[wdt_rst_pkg::FLAG_CODE] & ~(wr_flag & ~hwdata[wdt_rst_pkg::FLAG_CODE]));
			reset_flags[wdt_rst_pkg::FLAG_LV] <= lv_fire |
				(reset_flags[wdt_rst_pkg::FLAG_LV] & ~(wr_flag & ~hwdata[wdt_rst_pkg::FLAG_LV]));
			if (overflow)
				watchdog_expired_flag <= 1'b1;
			else if (halt_instruction | clear_watchdog_instruction)
				watchdog_expired_flag <= 1'b0;
			if (halt_instruction)
				power_down_flag <= 1'b1;
			else if (clear_watchdog_instruction)
				power_down_flag <= 1'b0;
			if (halt_instruction)
				asleep <= 1'b1;
			else if (wake_pulse | device_reset)
				asleep <= 1'b0;
			low_voltage_enable <= ~(halt_instruction | (asleep & ~wake_pulse));
		end
	end

	// ==========================================
	// checks

	// helper: length of the present low-voltage run, kept apart from the qualifier
	logic [7:0] lv_run;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			lv_run <= 8'h00;
		else if (!lv_s[1] || !low_voltage_enable)
			lv_run <= 8'h00;
		else if (lv_run != 8'hFF)
			lv_run <= lv_run + 8'h01;
	end

	// a corrupted key raises its flag and holds the device in reset
	a_key_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		key_fire |=> reset_flags[0] && device_reset) else $error("key flag or reset missing");

	// the code flag follows an undefined threshold code
	a_code_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!code_ok |=> reset_flags[1]) else $error("code flag missing");

	// unimplemented flag bits stay zero
	a_zero_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		flag_rd[6:3] == 4'h0) else $error("unimplemented bits not zero");

	// overflow while running resets the device
	a_run_overflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(overflow && !asleep && state == wdt_rst_pkg::ST_RUN) |=> device_reset && watchdog_expired_flag)
		else $error("run overflow no reset");

	// overflow while asleep only marks the flag and starts the wake
	a_sleep_overflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(overflow && asleep && state == wdt_rst_pkg::ST_RUN) |=> !device_reset && watchdog_expired_flag)
		else $error("sleep overflow wrong");

	// the clear instruction empties the count
	a_count_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clear_watchdog_instruction |=> watchdog_counter == 19'h00000) else $error("count not cleared");

	// halt empties the count as well
	a_halt_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_instruction |=> watchdog_counter == 19'h00000) else $error("count not cleared by halt");

	// a genuine low-voltage reset leaves the threshold alone
	a_lv_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lv_fire && !wr_lvs && !code_fire) |=> $stable(low_voltage_select)) else $error("threshold lost");

	// only a run longer than the minimum may qualify
	a_lv_short: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lv_fire |-> lv_run >= 8'(wdt_rst_pkg::LV_MIN_CYCLES)) else $error("short low voltage fired");

	// a qualified low voltage raises its flag
	a_lv_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lv_fire |=> reset_flags[2]) else $error("low voltage flag missing");

	// halt turns the low-voltage reset off and marks power down
	a_pd_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_instruction |=> !low_voltage_enable && power_down_flag) else $error("power down lv on");

	// the clear instruction alone drops the power-down flag
	a_pdf_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clear_watchdog_instruction && !halt_instruction) |=> !power_down_flag) else $error("pdf kept");

	// a bad code reloads the threshold to its power-on value
	a_code_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		code_fire |=> low_voltage_select == wdt_rst_pkg::RST_LOW_VOLTAGE_SELECT) else $error("code not reloaded");

	// a corrupted key reset puts the control register back to its power-on value
	a_key_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		key_fire |=> watchdog_control == wdt_rst_pkg::RST_WATCHDOG_CONTROL) else $error("control not reloaded");

	// the wake clears pc and sp without a full reset
	a_wake_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wake_pulse |-> pc_sp_clear && !device_reset) else $error("wake without pc clear");

	// the slave never stalls and never errors
	a_bus_okay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hreadyout && !hresp) else $error("bus not ready or error");

	c_run_reset: cover property (@(posedge ref_clk) disable iff (!rst_n) overflow && !asleep);
	c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) wake_pulse);
	c_key: cover property (@(posedge ref_clk) disable iff (!rst_n) key_fire);
	c_code: cover property (@(posedge ref_clk) disable iff (!rst_n) code_fire);
	c_lv: cover property (@(posedge ref_clk) disable iff (!rst_n) lv_fire);
endmodule

// ### inc/wdt_rst_pkg.sv
// package: constants for the watchdog and reset-source control block
// assumes: one 100 MHz clock, slow sub clock arrives as a pin level
package wdt_rst_pkg;
	// ==========================================
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_RESET_FLAG_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_LOW_VOLTAGE_SELECT = 8'h08;
	localparam logic [7:0] ADDR_STATUS             = 8'h0C;
	// ==========================================
	// reset values
	localparam logic [7:0] RST_WATCHDOG_CONTROL    = 8'h53;
	localparam logic [7:0] RST_RESET_FLAG_CONTROL  = 8'h00;
	localparam logic [7:0] RST_LOW_VOLTAGE_SELECT  = 8'h55;
	// ==========================================
	// field positions
	localparam int KEY_MSB       = 7;
	localparam int KEY_LSB       = 3;
	localparam int SEL_MSB       = 2;
	localparam int FLAG_KEY      = 0;
	localparam int FLAG_CODE     = 1;
	localparam int FLAG_LV       = 2;
	localparam int FLAG_IDLE_KEEP = 7;
	// ==========================================
	// codes
	localparam logic [4:0] KEY_A   = 5'h15;
	localparam logic [4:0] KEY_B   = 5'h0A;
	localparam logic [7:0] CODE_0  = 8'h55;
	localparam logic [7:0] CODE_1  = 8'h33;
	localparam logic [7:0] CODE_2  = 8'h99;
	localparam logic [7:0] CODE_3  = 8'hAA;
	// ==========================================
	// timing, counted in slow sub clock edges or system cycles, or given in ns or us
	localparam int          CORRUPT_DELAY_SUB   = 2;
	localparam int          LV_MIN_DURATION_NS  = 1000;
	localparam int          CLK_PERIOD_NS       = 10;
	localparam int          LV_MIN_CYCLES       = (LV_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          POWER_ON_DELAY_US   = 16700;
	localparam int          POWER_ON_CYCLES     = POWER_ON_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int          STARTUP_HIGH_RC     = 16;
	localparam int          STARTUP_CRYSTAL     = 128;
	localparam int          STARTUP_LOW_RC      = 2;
	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_HOLD  = 4'b0010,
		ST_WAKE  = 4'b0100,
		ST_PEND  = 4'b1000
	} seq_state_t;
endpackage

// ### testbench/watchdog_and_reset_control_tb.sv
// file: self-checking bench for the watchdog and reset-source block
// assumes: AHB-Lite slave answers with zero wait, fast sub clocks in sim, short power-on hold
`timescale 1ns/1ps
module watchdog_and_reset_control_tb;
	// ==========================================
	// stimulus and observed signals
	localparam int HOLD  = 50;
	localparam int LIMIT = 20000;
	logic        ref_clk = 1'b0;
	logic        rst_n, hsel, hwrite, low_rc_clk, crystal_clk, sub_clock_sel, low_voltage_in;
	logic        clear_watchdog_instruction, halt_instruction;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, device_reset, pc_sp_clear, wake_pulse;
	logic        watchdog_expired_flag, power_down_flag, low_voltage_enable;
	int          error_cnt, check_count, cycles, i;
	logic [7:0]  codes [4];

	watchdog_and_reset_control #(.POWER_ON_CYCLES_P(HOLD), .OSC_KIND(0)) watchdog_and_reset_control_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .low_rc_clk(low_rc_clk), .crystal_clk(crystal_clk), .sub_clock_sel(sub_clock_sel),
		.low_voltage_in(low_voltage_in), .clear_watchdog_instruction(clear_watchdog_instruction),
		.halt_instruction(halt_instruction), .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
		.wake_pulse(wake_pulse), .watchdog_expired_flag(watchdog_expired_flag),
		.power_down_flag(power_down_flag), .low_voltage_enable(low_voltage_enable));

	// ==========================================
	// clocks: sub clocks unrelated in phase to ref_clk and sped up so timeouts stay short
	always #5 ref_clk = ~ref_clk;
	always #41 low_rc_clk = ~low_rc_clk;
	always #47 crystal_clk = ~crystal_clk;

	// hang guard, counts as a mismatch
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			error_cnt++;
			summarize();
		end
	end

	// ==========================================
	// shared tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one single-word transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		hsize  <= 3'b010;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
		bus(1'b0, a, 32'h00000000);
		check($sformatf("reg_%h", a), rd & {24'hFFFFFF, mask}, {24'h000000, exp});
		check("ready_okay", {30'h0, hreadyout, hresp}, 32'h2);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wait_rst(input logic lvl, input int max);
		int n;
		for (n = 0; n < max && device_reset !== lvl; n++) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse(input int which);
		@(posedge ref_clk);
		if (which == 0) clear_watchdog_instruction <= 1'b1;
		else halt_instruction <= 1'b1;
		@(posedge ref_clk);
		clear_watchdog_instruction <= 1'b0;
		halt_instruction <= 1'b0;
		#1;
	endtask

	// power-on style hold: still high near the end, low soon after
	task automatic hold_chk();
		cyc(HOLD - 5);
		check("hold", device_reset, 32'h1);
		wait_rst(1'b0, 40);
		check("release", device_reset, 32'h0);
	endtask

	// corruption reset: not at once, then within a few sub clocks, then released
	task automatic corrupt_rst();
		cyc(5);
		check("early_reset", device_reset, 32'h0);
		wait_rst(1'b1, 60);
		check("reset", device_reset, 32'h1);
		wait_rst(1'b0, HOLD + 60);
	endtask

	// ==========================================
	// main sequence
	initial begin
		{rst_n, hsel, hwrite, low_rc_clk, crystal_clk, sub_clock_sel, low_voltage_in} = 7'b0;
		{clear_watchdog_instruction, halt_instruction, htrans, hsize} = 7'b0;
		{haddr, hwdata} = 64'h0;
		{error_cnt, check_count, cycles} = 0;
		codes = '{wdt_rst_pkg::CODE_0, wdt_rst_pkg::CODE_1, wdt_rst_pkg::CODE_2, wdt_rst_pkg::CODE_3};
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		hold_chk();
		rd_chk(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, wdt_rst_pkg::RST_WATCHDOG_CONTROL, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, wdt_rst_pkg::RST_LOW_VOLTAGE_SELECT, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_STATUS, 8'h00, 8'hFF);
		rd_chk(8'h10, 8'h00, 8'hFF);
		wr(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h80, 8'hFF);
		// every defined code and both keys are accepted with no reset
		for (i = 0; i < 4; i++) begin
			wr(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, codes[i]);
			rd_chk(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, codes[i], 8'hFF);
		end
		wr(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, {wdt_rst_pkg::KEY_A, 3'b011});
		wr(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, {wdt_rst_pkg::KEY_B, 3'b011});
		rd_chk(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, {wdt_rst_pkg::KEY_B, 3'b011}, 8'hFF);
		cyc(60);
		check("no_reset", device_reset, 32'h0);
		// undefined threshold code
		wr(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, 8'h12);
		corrupt_rst();
		rd_chk(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, wdt_rst_pkg::RST_LOW_VOLTAGE_SELECT, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h02, 8'h7F);
		rd_chk(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, wdt_rst_pkg::RST_WATCHDOG_CONTROL, 8'hFF);
		wr(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00, 8'h7F);
		// corrupted key field
		wr(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, 8'h03);
		corrupt_rst();
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h01, 8'h7F);
		wr(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h01);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h01, 8'h7F);
		wr(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00, 8'h7F);
		// low voltage: a short dip is ignored, a long one resets and keeps the threshold
		wr(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, wdt_rst_pkg::CODE_1);
		@(posedge ref_clk) low_voltage_in <= 1'b1;
		cyc(50);
		@(posedge ref_clk) low_voltage_in <= 1'b0;
		cyc(40);
		check("short_dip", device_reset, 32'h0);
		@(posedge ref_clk) low_voltage_in <= 1'b1;
		wait_rst(1'b1, 200);
		check("lv_reset", device_reset, 32'h1);
		@(posedge ref_clk) low_voltage_in <= 1'b0;
		wait_rst(1'b0, HOLD + 60);
		rd_chk(wdt_rst_pkg::ADDR_LOW_VOLTAGE_SELECT, wdt_rst_pkg::CODE_1, 8'hFF);
		rd_chk(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h04, 8'h7F);
		wr(wdt_rst_pkg::ADDR_RESET_FLAG_CONTROL, 8'h00);
		// run overflow at 2^8 sub clocks after a clear
		wr(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, {wdt_rst_pkg::KEY_B, 3'b000});
		pulse(0);
		cyc(2000);
		check("before_overflow", device_reset, 32'h0);
		wait_rst(1'b1, 400);
		check("overflow_reset", device_reset, 32'h1);
		check("expired", watchdog_expired_flag, 32'h1);
		hold_chk();
		rd_chk(wdt_rst_pkg::ADDR_STATUS, 8'h01, 8'h01);
		rd_chk(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, wdt_rst_pkg::RST_WATCHDOG_CONTROL, 8'hFF);
		// sleep on the crystal sub clock: low voltage ignored, overflow only wakes
		sub_clock_sel <= 1'b1;
		wr(wdt_rst_pkg::ADDR_WATCHDOG_CONTROL, {wdt_rst_pkg::KEY_A, 3'b000});
		pulse(1);
		cyc(2);
		check("pdf_set", power_down_flag, 32'h1);
		check("lv_off", low_voltage_enable, 32'h0);
		cyc(1000);
		@(posedge ref_clk) low_voltage_in <= 1'b1;
		cyc(200);
		@(posedge ref_clk) low_voltage_in <= 1'b0;
		cyc(1100);
		check("sleep_no_reset", device_reset, 32'h0);
		for (i = 0; i < 500 && wake_pulse !== 1'b1; i++) cyc(1);
		check("wake", wake_pulse, 32'h1);
		check("pc_sp", pc_sp_clear, 32'h1);
		check("sleep_expired", watchdog_expired_flag, 32'h1);
		check("sleep_full_reset", device_reset, 32'h0);
		check("pdf_kept", power_down_flag, 32'h1);
		pulse(0);
		cyc(2);
		check("pdf_clear", power_down_flag, 32'h0);
		check("lv_on", low_voltage_enable, 32'h1);
		summarize();
	end
endmodule
